// ===== src/mpd_pkg.sv
// Constants and carrier types for the multipurpose pin power-on delay block
package mpd_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_STEP_NS = 1000000;
   localparam int MS_CYCLES = (MS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_CNT_W = 15;
   // Register layout
   localparam int REG_W = 8;
   localparam int DELAY_W = 7;
   localparam int DELAY_LSB = 0;
   localparam int SEL_W = 4;
   localparam int SEL_LSB = 0;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;
   localparam logic [REG_W-1:0] REG_WMASK = 8'h7F;
   // Power-good sources
   localparam int PG_SRC_N = 10;
   localparam logic [SEL_W-1:0] SEL_BUCK_ONE = 4'h0;
   localparam logic [SEL_W-1:0] SEL_BUCK_TWO = 4'h1;
   localparam logic [SEL_W-1:0] SEL_BUCK_THREE = 4'h2;
   localparam logic [SEL_W-1:0] SEL_BUCK_FOUR = 4'h3;
   localparam logic [SEL_W-1:0] SEL_BUCK_FIVE = 4'h4;
   localparam logic [SEL_W-1:0] SEL_BUCK_SIX = 4'h5;
   localparam logic [SEL_W-1:0] SEL_LDO_ONE = 4'h6;
   localparam logic [SEL_W-1:0] SEL_LDO_TWO = 4'h7;
   localparam logic [SEL_W-1:0] SEL_LDO_THREE = 4'h8;
   localparam logic [SEL_W-1:0] SEL_DDR_TERM_REF = 4'h9;
   localparam logic [SEL_W-1:0] SEL_ALL_AND = 4'hA;

   typedef struct packed {
      logic wr;
      logic [REG_W-1:0] wdata;
   } mpd_reg_wr_s;

   typedef struct packed {
      logic ddr_termination_reference;
      logic [2:0] ldo;
      logic [5:0] buck;
   } mpd_pg_s;

   typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_DONE} mpd_state_e;
endpackage

// ===== src/mpd_ms_timer.sv
// Millisecond tick generator, restartable
`timescale 1ns/1ps
module mpd_ms_timer import mpd_pkg::*; #(
   parameter int CYCLES_PER_MS = MS_CYCLES
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // Control
   input wire logic restart_i,
   input wire logic run_i,
   // Tick out
   output logic tick_o
);
   localparam logic [MS_CNT_W-1:0] LAST = MS_CNT_W'(CYCLES_PER_MS - 1);

   logic [MS_CNT_W-1:0] cnt_q;
   logic [MS_CNT_W-1:0] cnt_d;
   wire at_last = (cnt_q == LAST);

   assign cnt_d = (restart_i || !run_i || at_last) ? '0 : cnt_q + 1'b1;
   // Tick only while running, so a restart always gives a full first step
   assign tick_o = run_i && !restart_i && at_last;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnt_q <= '0;
      end else if (clk_en_i) begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// ===== src/mpd_power_on_delay.sv
// Power-on delay and power-good source selection for multipurpose pin five
// What this block does
// - Seven-bit field counts whole milliseconds: 0 none, 1 is 1 ms, up to 127 ms.
// - Delay is timed from power-on sequence start, not from earlier regulators.
// - In power-good mode, low four bits select the reported regulator power-good.
// - Codes 0000 to 0100 select buck regulators one to five.
// - 0101 buck six, 0110-1000 linear regulators, 1001 termination reference, 1010 AND.
`timescale 1ns/1ps
module mpd_power_on_delay import mpd_pkg::*; #(
   parameter int CYCLES_PER_MS = MS_CYCLES
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // Register access
   input wire mpd_reg_wr_s reg_wr_i,
   output logic [REG_W-1:0] reg_rdata_o,
   // Nonvolatile load
   input wire logic nvm_load_i,
   input wire logic [REG_W-1:0] nvm_data_i,
   // Sequencer
   input wire logic seq_start_i,
   input wire logic seq_stop_i,
   input wire logic power_good_mode_i,
   // Regulator power-good levels, asynchronous
   input wire mpd_pg_s power_good_i,
   // Pin
   output logic multipurpose_io_five_o,
   output logic delay_done_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Register
   logic [REG_W-1:0] field_q;
   logic [REG_W-1:0] field_d;
   wire reg_write = reg_wr_i.wr;
   wire [REG_W-1:0] wr_value = reg_wr_i.wdata & REG_WMASK;
   wire [REG_W-1:0] nvm_value = nvm_data_i & REG_WMASK;

   // Software write after nonvolatile load in the same cycle: software wins
   assign field_d = reg_write ? wr_value :
                    nvm_load_i ? nvm_value : field_q;
   assign reg_rdata_o = field_q & REG_WMASK;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         field_q <= REG_RESET;
      end else if (clk_en_i) begin
         field_q <= field_d;
      end
   end

   wire [DELAY_W-1:0] delay_code = field_q[DELAY_LSB +: DELAY_W];
   wire [SEL_W-1:0] sel_code = field_q[SEL_LSB +: SEL_W];

   ////////////////////////////////////////////////////////////////////////////
   // Power-good synchronisers
   logic [PG_SRC_N-1:0] pg_meta_q;
   logic [PG_SRC_N-1:0] pg_sync_q;

   // Only the second stage is read; the first may still be settling
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pg_meta_q <= '0;
      end else if (clk_en_i) begin
         pg_meta_q <= power_good_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pg_sync_q <= '0;
      end else if (clk_en_i) begin
         pg_sync_q <= pg_meta_q;
      end
   end

   mpd_pg_s pg;
   assign pg = pg_sync_q;

   ////////////////////////////////////////////////////////////////////////////
   // Source selection
   wire pg_all_good = &pg_sync_q;
   logic pg_sel;

   always_comb begin
      unique case (sel_code)
         SEL_BUCK_ONE: pg_sel = pg.buck[0];
         SEL_BUCK_TWO: pg_sel = pg.buck[1];
         SEL_BUCK_THREE: pg_sel = pg.buck[2];
         SEL_BUCK_FOUR: pg_sel = pg.buck[3];
         SEL_BUCK_FIVE: pg_sel = pg.buck[4];
         SEL_BUCK_SIX: pg_sel = pg.buck[5];
         SEL_LDO_ONE: pg_sel = pg.ldo[0];
         SEL_LDO_TWO: pg_sel = pg.ldo[1];
         SEL_LDO_THREE: pg_sel = pg.ldo[2];
         SEL_DDR_TERM_REF: pg_sel = pg.ddr_termination_reference;
         SEL_ALL_AND: pg_sel = pg_all_good;
         // Undefined codes report not-good rather than a random source
         default: pg_sel = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay sequencer
   mpd_state_e state_q;
   mpd_state_e state_d;
   mpd_state_e start_state;
   logic [DELAY_W-1:0] target_q;
   logic [DELAY_W-1:0] target_d;
   logic [DELAY_W-1:0] ms_q;
   logic [DELAY_W-1:0] ms_d;
   logic tick;

   wire in_count = (state_q == ST_COUNT);
   wire in_done = (state_q == ST_DONE);
   wire [DELAY_W-1:0] ms_next = ms_q + 1'b1;

   // Delay latched at start so a mid-sequence write cannot shorten it
   wire start_zero = seq_start_i && (delay_code == '0);
   wire reached = tick && (ms_next == target_q);
   assign start_state = start_zero ? ST_DONE : ST_COUNT;

   // Start beats stop in the same cycle; a start mid-count restarts the delay
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (seq_start_i) begin
               state_d = start_state;
            end
         end
         ST_COUNT: begin
            if (seq_start_i) begin
               state_d = start_state;
            end else if (seq_stop_i) begin
               state_d = ST_IDLE;
            end else if (reached) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (seq_start_i) begin
               state_d = start_state;
            end else if (seq_stop_i) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   // Millisecond index restarts with every accepted start
   assign target_d = seq_start_i ? delay_code : target_q;
   assign ms_d = seq_start_i ? '0 : (tick ? ms_next : ms_q);

   mpd_ms_timer #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_timer (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .restart_i(seq_start_i),
      .run_i(in_count),
      .tick_o(tick)
   );

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
      end else if (clk_en_i) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         target_q <= '0;
      end else if (clk_en_i) begin
         target_q <= target_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ms_q <= '0;
      end else if (clk_en_i) begin
         ms_q <= ms_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin output
   logic pin_q;
   logic pin_d;
   logic done_q;
   logic done_d;

   // Registered so a selector change never glitches the board net
   // Delay mode drops the pin on stop; power-good mode ignores the sequencer
   assign pin_d = power_good_mode_i ? pg_sel : in_done;
   assign done_d = in_done;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         pin_q <= 1'b0;
      end else if (clk_en_i) begin
         pin_q <= pin_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         done_q <= 1'b0;
      end else if (clk_en_i) begin
         done_q <= done_d;
      end
   end

   assign multipurpose_io_five_o = pin_q;
   assign delay_done_o = done_q;
endmodule

// ===== verif/mpd_power_on_delay_monitor.sv
// Checker for the power-on delay block
`timescale 1ns/1ps
module mpd_mon import mpd_pkg::*; #(
   parameter int CYCLES_PER_MS = MS_CYCLES
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // Register access
   input wire mpd_reg_wr_s reg_wr_i,
   input wire logic [REG_W-1:0] reg_rdata_o,
   // Nonvolatile load
   input wire logic nvm_load_i,
   input wire logic [REG_W-1:0] nvm_data_i,
   // Sequencer
   input wire logic seq_start_i,
   input wire logic seq_stop_i,
   input wire logic power_good_mode_i,
   input wire mpd_pg_s power_good_i,
   // Pin
   input wire logic multipurpose_io_five_o,
   input wire logic delay_done_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // Wide enough for the longest delay at the full-rate step count
   logic [31:0] cnt_q;
   logic [6:0] code_q;
   // Code 0 rises one edge after start, code N one edge after N steps
   wire [31:0] exp_w = 32'(code_q * CYCLES_PER_MS + 2);
   // Cycles since the last accepted start, with the code it latched
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         cnt_q <= 32'h00000000;
         code_q <= 7'h00;
      end else if (clk_en_i && seq_start_i) begin
         cnt_q <= 32'h00000001;
         code_q <= reg_rdata_o[6:0];
      end else if (clk_en_i) begin
         cnt_q <= cnt_q + 32'h00000001;
      end
   end
   a_top_bit_zero: assert property (!reg_rdata_o[7]) else $error("top bit set");
   a_write_lands: assert property (reg_wr_i.wr && clk_en_i |=> reg_rdata_o == {1'b0, $past(reg_wr_i.wdata[6:0])})
      else $error("write lost");
   a_nvm_lands: assert property (nvm_load_i && !reg_wr_i.wr && clk_en_i |=> reg_rdata_o[6:0] == $past(nvm_data_i[6:0]))
      else $error("load lost");
   a_reg_holds: assert property (!(clk_en_i && (reg_wr_i.wr || nvm_load_i)) |=> $stable(reg_rdata_o))
      else $error("register moved");
   a_done_timing: assert property ($rose(delay_done_o) |-> cnt_q == exp_w) else $error("delay length");
   a_stop_clears: assert property (seq_stop_i && !seq_start_i && clk_en_i |-> ##2 !delay_done_o)
      else $error("stop ignored");
   a_pg_buck_one: assert property ((power_good_mode_i && clk_en_i && $stable(power_good_i) && reg_rdata_o == 8'h00)[*4]
      |-> multipurpose_io_five_o == power_good_i.buck[0]) else $error("selector 0");
   a_pg_unused_low: assert property ((power_good_mode_i && clk_en_i && reg_rdata_o[3:0] > 4'hA)[*4]
      |-> !multipurpose_io_five_o) else $error("unused selector");
   c_start: cover property (seq_start_i && clk_en_i);
   c_nvm: cover property (nvm_load_i && clk_en_i);
   c_and: cover property (power_good_mode_i && reg_rdata_o == 8'h0A && multipurpose_io_five_o);
endmodule
bind mpd_power_on_delay mpd_mon #(.CYCLES_PER_MS(CYCLES_PER_MS)) mpd_mon_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
   .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .nvm_load_i(nvm_load_i),
   .nvm_data_i(nvm_data_i), .seq_start_i(seq_start_i), .seq_stop_i(seq_stop_i),
   .power_good_mode_i(power_good_mode_i), .power_good_i(power_good_i),
   .multipurpose_io_five_o(multipurpose_io_five_o), .delay_done_o(delay_done_o));

// ===== verif/tb.sv
// Self-checking bench for the power-on delay block
`timescale 1ns/1ps
module tb;
   import mpd_pkg::*;
   typedef struct {string what; logic [7:0] v;} mpd_note_s;
   logic clk = 0, rst = 1, en = 1, ld = 0, start = 0, stop = 0, mode = 0, pin, done;
   logic [7:0] nvm = 8'h00, rdata;
   logic [31:0] seed = 36069, d;
   mpd_reg_wr_s wr = '0;
   mpd_pg_s pg = '0;
   mpd_note_s q[$];
   event ev;
   int n_fail = 0, check_count = 0;
   always #20 clk = ~clk;
   mpd_power_on_delay #(.CYCLES_PER_MS(4)) mpd_power_on_delay_i (.sys_clk_i(clk), .reset_i(rst), .clk_en_i(en),
      .reg_wr_i(wr), .reg_rdata_o(rdata), .nvm_load_i(ld), .nvm_data_i(nvm), .seq_start_i(start),
      .seq_stop_i(stop), .power_good_mode_i(mode), .power_good_i(pg), .multipurpose_io_five_o(pin), .delay_done_o(done));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic note(string what, logic [7:0] v);
      q.push_back('{what, v});
      ->ev;
   endtask
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(ev) begin
      mpd_note_s n;
      while (q.size() > 0) begin
         n = q.pop_front();
         check(n.what, (n.what == "rdata") ? rdata : {7'h00, (n.what == "pin") ? pin : done}, n.v);
      end
   end
   task automatic put_reg(logic [7:0] v);
      wr = '{1'b1, v};
      tick(1);
      wr.wr = 1'b0;
      // Idle edge so back-to-back calls never raise the strobe in the step that lowers it
      tick(1);
   endtask
   // Stop first so a stale done cannot mask a late rise
   task automatic run(logic [6:0] c);
      put_reg({1'b0, c});
      stop = 1;
      tick(1);
      stop = 0;
      tick(1);
      start = 1;
      tick(1);
      start = 0;
      tick(c * 4);
      note("done", 8'h00);
      tick(1);
      note("done", 8'h01);
      note("pin", 8'h01);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      conclude();
   end
   initial begin
      tick(3);
      rst = 0;
      note("rdata", 8'h00);
      put_reg(8'hFF);
      note("rdata", 8'h7F);
      en = 0;
      put_reg(8'h12);
      note("rdata", 8'h7F);
      en = 1;
      nvm = 8'h85;
      ld = 1;
      tick(1);
      ld = 0;
      note("rdata", 8'h05);
      repeat (6) begin
         d = rnd();
         put_reg(d[7:0]);
         note("rdata", {1'b0, d[6:0]});
      end
      run(0);
      run(1);
      run(3);
      run(127);
      // Mid-count write lands in the register, but the two-step delay latched at start still runs
      put_reg(8'h02);
      start = 1;
      tick(1);
      start = 0;
      put_reg(8'h7F);
      tick(6);
      note("done", 8'h00);
      tick(1);
      note("done", 8'h01);
      note("pin", 8'h01);
      mode = 1;
      // Third pass forces all good so the AND code can go high
      for (int s = 0; s < 16; s++) begin
         for (int p = 0; p < 3; p++) begin
            d = rnd();
            pg = (p == 2) ? 10'h3FF : d[9:0];
            put_reg(8'(s));
            tick(4);
            note("pin", {7'h00, (s < 10) ? pg[s] : (s == 10) ? &pg : 1'b0});
         end
      end
      tick(1);
      conclude();
   end
endmodule
